// ### frg_pkg.sv
// shared constants for the frequency reference generator
package frg_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_BACKUP_MODE  = 8'h00;
  localparam logic [7:0] OFF_KEYPAD_REF   = 8'h04;
  localparam logic [7:0] OFF_JOG_REF      = 8'h08;
  localparam logic [7:0] OFF_PRESET_BASE  = 8'h0C;
  localparam logic [7:0] OFF_LOWER_LIMIT  = 8'h2C;
  localparam logic [7:0] OFF_UPPER_LIMIT  = 8'h30;
  localparam logic [7:0] OFF_SOURCE_SEL   = 8'h34;
  localparam logic [7:0] OFF_DI_FUNCTION  = 8'h38;
  localparam logic [7:0] OFF_CONTROL_WORD = 8'h3C;
  localparam logic [7:0] OFF_SERIAL_REF   = 8'h40;
  localparam logic [7:0] OFF_RATED_FREQ   = 8'h44;
  localparam logic [7:0] OFF_EP_TICK      = 8'h48;
  localparam logic [7:0] OFF_STATUS       = 8'h4C;
  localparam logic [7:0] OFF_SPEED_MON    = 8'h50;
  localparam logic [7:0] OFF_LAST         = 8'h50;
  // reset values, frequencies in 0.1 Hz units
  localparam logic [15:0] RST_BACKUP_MODE = 16'h0000;
  localparam logic [15:0] RST_KEYPAD_REF  = 16'h001E;
  localparam logic [15:0] RST_JOG_REF     = 16'h0032;
  localparam logic [15:0] RST_LOWER_LIMIT = 16'h001E;
  localparam logic [15:0] RST_UPPER_LIMIT = 16'h0294;
  localparam logic [15:0] RST_RATED_FREQ  = 16'h0258;
  localparam logic [15:0] RST_EP_TICK     = 16'h07D0;
  localparam logic [15:0] RST_SOURCE_SEL  = 16'h0020;
  localparam logic [15:0] RST_PRESET [8] = '{16'h001E, 16'h00C8, 16'h00C8, 16'h0190,
                                             16'h0190, 16'h01F4, 16'h0258, 16'h0294};
  localparam logic signed [15:0] REF_MAX  = 16'sh0BB8;
  localparam logic signed [15:0] REF_MIN  = -16'sh0BB8;
  // reference source codes
  localparam logic [3:0] SRC_KEYPAD = 4'h0;
  localparam logic [3:0] SRC_ANALOG = 4'h1;
  localparam logic [3:0] SRC_FREQ   = 4'h4;
  localparam logic [3:0] SRC_EPOT   = 4'h7;
  localparam logic [3:0] SRC_MULTI  = 4'h8;
  localparam logic [3:0] SRC_SERIAL = 4'h9;
  localparam logic [3:0] SRC_FBUS   = 4'hB;
  localparam logic [3:0] SRC_SLC    = 4'hC;
  // digital input function codes
  localparam logic [5:0] FN_EP_UP_A  = 6'h0B;
  localparam logic [5:0] FN_EP_DN_A  = 6'h0C;
  localparam logic [5:0] FN_EP_UP_B  = 6'h21;
  localparam logic [5:0] FN_EP_DN_B  = 6'h22;
  localparam logic [5:0] FN_MS_MSB   = 6'h0D;
  localparam logic [5:0] FN_MS_MID   = 6'h0E;
  localparam logic [5:0] FN_MS_LSB   = 6'h0F;
  // control word bits, then serial scale shift, divider steps and speed saturation
  localparam int CW_GEN_ENABLE = 1;
  localparam int CW_FORWARD    = 2;
  localparam int CW_JOG        = 3;
  localparam int CW_REMOTE     = 4;
  localparam int SCALE_SHIFT   = 13;
  localparam logic [4:0] DIV_STEPS = 5'h1D;
  localparam logic [15:0] SPEED_SAT = 16'h7FFF;
endpackage : frg_pkg

// ### frg_reference.sv
// frequency reference generator: sources, limits, backup, multispeed, e.p., 13-bit scale
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module frg_reference (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins, asynchronous
  input  wire logic [3:0]  digital_input,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        monitoring_mode,
  input  wire logic        drive_enable,
  input  wire logic        inching_command,
  // conditioned references, 0.1 Hz signed, pclk domain
  input  wire logic [15:0] analog_reference,
  input  wire logic [15:0] frequency_input,
  input  wire logic [15:0] fieldbus_reference,
  input  wire logic [15:0] slc_reference,
  // ramp side
  output logic [15:0]      ramp_reference,
  output logic             ramp_forward,
  output logic             drive_enabled,
  output logic             jog_active,
  output logic             config_incompatible_state,
  output logic [15:0]      keypad_display
);

  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : clamp

  function automatic logic fn_is(input logic [23:0] f, input logic [5:0] a,
                                 input logic [5:0] b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (f[i*6 +: 6] == a || f[i*6 +: 6] == b) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fn_is

  // register file
  logic [1:0]         backup_mode_r;
  logic signed [15:0] keypad_ref_r;
  logic signed [15:0] jog_ref_r;
  logic signed [15:0] preset_r [8];
  logic signed [15:0] lower_r;
  logic signed [15:0] upper_r;
  logic [15:0]        source_sel_r;
  logic [23:0]        di_fn_r;
  logic [15:0]        ctrl_word_r;
  logic signed [15:0] ser13_r;
  logic [15:0]        rated_r;
  logic [15:0]        ep_tick_r;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [3:0]  preset_idx;
  logic        preset_hit;
  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & ~penable & ~pwrite;
  assign addr_ok    = (paddr[1:0] == 2'b00) && (paddr <= frg_pkg::OFF_LAST);
  assign preset_hit = (paddr >= frg_pkg::OFF_PRESET_BASE) && (paddr < frg_pkg::OFF_LOWER_LIMIT);
  assign preset_idx = 4'((paddr - frg_pkg::OFF_PRESET_BASE) >> 2);
  // zero wait state slave
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~addr_ok;

  // pin synchronisers; a change counts once stages 2 and 3 agree
  logic [8:0] pin_s1, pin_s2, pin_s3, pin_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 9'h000;
      pin_s2 <= 9'h000;
      pin_s3 <= 9'h000;
      pin_q  <= 9'h000;
    end else begin
      pin_s1 <= {inching_command, drive_enable, monitoring_mode, key_down, key_up,
                 digital_input};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_q <= pin_s3;
      end
    end
  end

  logic [3:0] di;
  logic       kup, kdn, kup_d, kdn_d, mon, en_pin, jog_pin;
  assign di      = pin_q[3:0];
  assign kup     = pin_q[4];
  assign kdn     = pin_q[5];
  assign mon     = pin_q[6];
  assign en_pin  = pin_q[7];
  assign jog_pin = pin_q[8];

  // multispeed msb may sit on only one of the first two inputs
  logic incompat;
  assign incompat = (di_fn_r[5:0] == frg_pkg::FN_MS_MSB) &&
                    (di_fn_r[11:6] == frg_pkg::FN_MS_MSB);

  // enable: pin and control word both, refused while incompatible
  logic en_r, en_d;
  logic enable_evt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r  <= 1'b0;
      en_d  <= 1'b0;
      kup_d <= 1'b0;
      kdn_d <= 1'b0;
    end else begin
      en_r  <= en_pin & ctrl_word_r[frg_pkg::CW_GEN_ENABLE] & ~incompat;
      en_d  <= en_r;
      kup_d <= kup;
      kdn_d <= kdn;
    end
  end
  assign enable_evt = en_r & ~en_d;

  // backup start value for the digital references
  logic               load_start;
  logic signed [15:0] start_val;
  assign load_start = enable_evt && (backup_mode_r != 2'd1);
  assign start_val  = (backup_mode_r == 2'd2) ? keypad_ref_r : lower_r;

  // register writes and keypad adjustment
  logic key_inc, key_dec;
  assign key_inc = mon & kup & ~kup_d;
  assign key_dec = mon & kdn & ~kdn_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_mode_r <= frg_pkg::RST_BACKUP_MODE[1:0];
      keypad_ref_r  <= frg_pkg::RST_KEYPAD_REF;
      jog_ref_r     <= frg_pkg::RST_JOG_REF;
      lower_r       <= frg_pkg::RST_LOWER_LIMIT;
      upper_r       <= frg_pkg::RST_UPPER_LIMIT;
      source_sel_r  <= frg_pkg::RST_SOURCE_SEL;
      di_fn_r       <= 24'h00_0000;
      ctrl_word_r   <= 16'h0000;
      ser13_r       <= 16'h0000;
      rated_r       <= frg_pkg::RST_RATED_FREQ;
      ep_tick_r     <= frg_pkg::RST_EP_TICK;
      for (int i = 0; i < 8; i++) begin
        preset_r[i] <= frg_pkg::RST_PRESET[i];
      end
    end else begin
      if (wr_en && addr_ok) begin
        case (paddr)
          frg_pkg::OFF_BACKUP_MODE:  backup_mode_r <= pwdata[1:0];
          frg_pkg::OFF_KEYPAD_REF:   keypad_ref_r  <= clamp(pwdata[15:0], 16'sh0000,
                                                           frg_pkg::REF_MAX);
          frg_pkg::OFF_JOG_REF:      jog_ref_r     <= clamp(pwdata[15:0], frg_pkg::REF_MIN,
                                                           frg_pkg::REF_MAX);
          frg_pkg::OFF_LOWER_LIMIT:  lower_r <= clamp(pwdata[15:0], 16'sh0000,
                                                      frg_pkg::REF_MAX);
          frg_pkg::OFF_UPPER_LIMIT:  upper_r <= clamp(pwdata[15:0], 16'sh0000,
                                                      frg_pkg::REF_MAX);
          frg_pkg::OFF_SOURCE_SEL:   source_sel_r <= {8'h00, pwdata[7:0]};
          frg_pkg::OFF_DI_FUNCTION:  di_fn_r      <= pwdata[23:0];
          frg_pkg::OFF_CONTROL_WORD: ctrl_word_r  <= pwdata[15:0];
          frg_pkg::OFF_SERIAL_REF:   ser13_r      <= pwdata[15:0];
          frg_pkg::OFF_RATED_FREQ:   rated_r      <= pwdata[15:0];
          frg_pkg::OFF_EP_TICK:      ep_tick_r    <= pwdata[15:0];
          default: begin
            if (preset_hit) begin
              preset_r[preset_idx[2:0]] <= clamp(pwdata[15:0], frg_pkg::REF_MIN,
                                                 frg_pkg::REF_MAX);
            end
          end
        endcase
      end else if (load_start) begin
        keypad_ref_r <= start_val;
      end else if (key_inc) begin
        // adjustment stops at the upper limit, software may still write higher
        keypad_ref_r <= (keypad_ref_r >= upper_r) ? keypad_ref_r
                                                  : keypad_ref_r + 16'sh0001;
      end else if (key_dec && keypad_ref_r > 16'sh0000) begin
        keypad_ref_r <= keypad_ref_r - 16'sh0001;
      end
    end
  end

  // serial reference held in 0.1 Hz so backup can overwrite it
  logic               ser_wr_d;
  logic signed [31:0] ser_prod;
  logic signed [15:0] ser_hz_r;
  assign ser_prod = 32'(ser13_r) * $signed({16'h0000, rated_r});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_wr_d <= 1'b0;
      ser_hz_r <= 16'sh0000;
    end else begin
      ser_wr_d <= wr_en && (paddr == frg_pkg::OFF_SERIAL_REF);
      if (ser_wr_d) begin
        ser_hz_r <= clamp(16'(ser_prod >>> frg_pkg::SCALE_SHIFT), frg_pkg::REF_MIN,
                          frg_pkg::REF_MAX);
      end else if (load_start) begin
        ser_hz_r <= start_val;
      end
    end
  end

  // electronic potentiometer
  logic               ep_up, ep_dn;
  logic [15:0]        ep_cnt_r;
  logic signed [15:0] ep_ref_r;
  logic [3:0]         ref_src;
  // inputs passed as arguments so the assigns follow pin and function changes
  assign ep_up = fn_hit(di, di_fn_r, frg_pkg::FN_EP_UP_A, frg_pkg::FN_EP_UP_B);
  assign ep_dn = fn_hit(di, di_fn_r, frg_pkg::FN_EP_DN_A, frg_pkg::FN_EP_DN_B);

  function automatic logic fn_hit(input logic [3:0] d, input logic [23:0] f,
                                  input logic [5:0] a, input logic [5:0] b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (d[i] && (f[i*6 +: 6] == a || f[i*6 +: 6] == b)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fn_hit

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_cnt_r <= 16'h0000;
      ep_ref_r <= frg_pkg::RST_LOWER_LIMIT;
    end else begin
      if (!en_r && ep_up && ep_dn) begin
        ep_ref_r <= lower_r;
        ep_cnt_r <= 16'h0000;
      end else if (load_start) begin
        ep_ref_r <= start_val;
      end else if (ref_src == frg_pkg::SRC_EPOT && (ep_up ^ ep_dn)) begin
        if (ep_cnt_r >= ep_tick_r) begin
          ep_cnt_r <= 16'h0000;
          ep_ref_r <= clamp(ep_up ? ep_ref_r + 16'sh0001 : ep_ref_r - 16'sh0001,
                            lower_r, upper_r);
        end else begin
          ep_cnt_r <= ep_cnt_r + 16'h0001;
        end
      end else begin
        ep_cnt_r <= 16'h0000;
      end
    end
  end

  // multispeed code, msb from either of the first two inputs
  logic [2:0] ms_code;
  always_comb begin
    ms_code = 3'b000;
    for (int i = 0; i < 4; i++) begin
      if (di[i] && di_fn_r[i*6 +: 6] == frg_pkg::FN_MS_MSB && i < 2) begin
        ms_code[2] = 1'b1;
      end
      if (di[i] && di_fn_r[i*6 +: 6] == frg_pkg::FN_MS_MID) begin
        ms_code[1] = 1'b1;
      end
      if (di[i] && di_fn_r[i*6 +: 6] == frg_pkg::FN_MS_LSB) begin
        ms_code[0] = 1'b1;
      end
    end
  end

  // source selection, local or remote per control word
  assign ref_src = ctrl_word_r[frg_pkg::CW_REMOTE] ? source_sel_r[7:4]
                                                   : source_sel_r[3:0];
  logic signed [15:0] sel_ref;
  logic               signed_src;
  always_comb begin
    signed_src = 1'b0;
    case (ref_src)
      frg_pkg::SRC_KEYPAD: sel_ref = keypad_ref_r;
      frg_pkg::SRC_ANALOG: sel_ref = analog_reference;
      frg_pkg::SRC_FREQ:   sel_ref = frequency_input;
      frg_pkg::SRC_EPOT:   sel_ref = ep_ref_r;
      frg_pkg::SRC_MULTI: begin
        sel_ref    = preset_r[ms_code];
        signed_src = 1'b1;
      end
      frg_pkg::SRC_SERIAL: sel_ref = ser_hz_r;
      frg_pkg::SRC_FBUS:   sel_ref = fieldbus_reference;
      frg_pkg::SRC_SLC:    sel_ref = slc_reference;
      default:             sel_ref = 16'sh0000;
    endcase
    if (jog_active) begin
      sel_ref    = jog_ref_r;
      signed_src = 1'b1;
    end
  end

  // magnitude clamp and direction to the ramp input
  logic               neg;
  logic signed [15:0] mag;
  assign neg = signed_src && sel_ref[15];
  assign mag = neg ? -sel_ref : (sel_ref[15] ? 16'sh0000 : sel_ref);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_reference <= 16'h0000;
      ramp_forward   <= 1'b0;
      jog_active     <= 1'b0;
    end else begin
      jog_active     <= en_r & (jog_pin | ctrl_word_r[frg_pkg::CW_JOG]);
      ramp_reference <= clamp(mag, lower_r, upper_r);
      ramp_forward   <= ctrl_word_r[frg_pkg::CW_FORWARD] ^ neg;
    end
  end

  // 13-bit speed monitor: reference * 8192 / rated, serial long division
  logic [4:0]  div_cnt_r;
  logic [28:0] num_r;
  logic [28:0] quo_r;
  logic [16:0] rem_r;
  logic [16:0] rem_sh;
  logic [15:0] speed_mon_r;
  logic        dir_lat_r;
  assign rem_sh = {rem_r[15:0], num_r[28]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r   <= 5'h00;
      num_r       <= 29'h0000_0000;
      quo_r       <= 29'h0000_0000;
      rem_r       <= 17'h0_0000;
      speed_mon_r <= 16'h0000;
      dir_lat_r   <= 1'b0;
    end else if (div_cnt_r == 5'h00) begin
      // result published in the same cycle the next run is loaded
      if (quo_r > 29'(frg_pkg::SPEED_SAT)) begin
        speed_mon_r <= dir_lat_r ? frg_pkg::SPEED_SAT : -frg_pkg::SPEED_SAT;
      end else begin
        speed_mon_r <= dir_lat_r ? quo_r[15:0] : -quo_r[15:0];
      end
      num_r     <= {ramp_reference, 13'h0000};
      dir_lat_r <= ramp_forward;
      quo_r     <= 29'h0000_0000;
      rem_r     <= 17'h0_0000;
      div_cnt_r <= frg_pkg::DIV_STEPS;
    end else begin
      num_r     <= {num_r[27:0], 1'b0};
      div_cnt_r <= div_cnt_r - 5'h01;
      if (rem_sh >= {1'b0, rated_r}) begin
        rem_r <= rem_sh - {1'b0, rated_r};
        quo_r <= {quo_r[27:0], 1'b1};
      end else begin
        rem_r <= rem_sh;
        quo_r <= {quo_r[27:0], 1'b0};
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        frg_pkg::OFF_BACKUP_MODE:  prdata <= {30'h0000_0000, backup_mode_r};
        frg_pkg::OFF_KEYPAD_REF:   prdata <= {16'h0000, keypad_ref_r};
        frg_pkg::OFF_JOG_REF:      prdata <= {16'h0000, jog_ref_r};
        frg_pkg::OFF_LOWER_LIMIT:  prdata <= {16'h0000, lower_r};
        frg_pkg::OFF_UPPER_LIMIT:  prdata <= {16'h0000, upper_r};
        frg_pkg::OFF_SOURCE_SEL:   prdata <= {16'h0000, source_sel_r};
        frg_pkg::OFF_DI_FUNCTION:  prdata <= {8'h00, di_fn_r};
        frg_pkg::OFF_CONTROL_WORD: prdata <= {16'h0000, ctrl_word_r};
        frg_pkg::OFF_SERIAL_REF:   prdata <= {16'h0000, ser13_r};
        frg_pkg::OFF_RATED_FREQ:   prdata <= {16'h0000, rated_r};
        frg_pkg::OFF_EP_TICK:      prdata <= {16'h0000, ep_tick_r};
        frg_pkg::OFF_STATUS:       prdata <= {5'h00, ms_code, ref_src, jog_active,
                                              ramp_forward, en_r, incompat,
                                              ramp_reference};
        frg_pkg::OFF_SPEED_MON:    prdata <= {16'h0000, speed_mon_r};
        default: begin
          if (preset_hit) begin
            prdata <= {16'h0000, preset_r[preset_idx[2:0]]};
          end else begin
            prdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  assign drive_enabled             = en_r;
  assign config_incompatible_state = incompat;
  assign keypad_display            = keypad_ref_r;

  logic unused_ok;
  assign unused_ok = fn_is(di_fn_r, frg_pkg::FN_MS_MSB, frg_pkg::FN_MS_MSB);

endmodule : frg_reference

// ### frg_assertions.sv
// port checker for the frequency reference generator
`timescale 1ns/100ps
module frg_assertions (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // drive side
  input wire logic        drive_enable,
  input wire logic        drive_enabled,
  input wire logic        config_incompatible_state,
  input wire logic [15:0] ramp_reference,
  input wire logic [15:0] keypad_display
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pin_low_s;
    !drive_enable [*6];
  endsequence
  sequence floor_s;
    ##[0:2] ramp_reference == 16'h001E;
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  err_address_a: assert property (psel && penable && paddr > 8'h50 |-> pslverr)
    else $error("no error on unmapped address");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  rdata_hold_a: assert property ($changed(prdata) |->
                                 $past(psel && !penable && !pwrite))
    else $error("read data moved without read setup");
  ramp_ceiling_a: assert property (ramp_reference <= 16'h0BB8)
    else $error("ramp above range");
  power_floor_a: assert property ($rose(presetn) |-> floor_s)
    else $error("power-up reference not lower limit");
  display_ceiling_a: assert property (keypad_display <= 16'h0BB8)
    else $error("keypad reference above range");
  incompat_refuse_a: assert property (config_incompatible_state |=> !drive_enabled)
    else $error("enabled while incompatible");
  pin_disable_a: assert property (pin_low_s |=> !drive_enabled)
    else $error("enabled with enable pin low");
endmodule : frg_assertions

bind frg_reference frg_assertions i_frg_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_enable(drive_enable), .drive_enabled(drive_enabled),
  .config_incompatible_state(config_incompatible_state),
  .ramp_reference(ramp_reference), .keypad_display(keypad_display)
);

// ### frg_keypad_model.sv
// keypad model pressing the up and down keys
`timescale 1ns/100ps
module frg_keypad_model (
  // clock
  input wire logic pclk,
  // keys
  output logic     key_up,
  output logic     key_down
);
  initial begin
    key_up   = 1'b0;
    key_down = 1'b0;
  end
  // held well past the input synchroniser so one press is one step
  task automatic press(input logic up);
    @(posedge pclk);
    key_up   <= up;
    key_down <= !up;
    repeat (8) @(posedge pclk);
    key_up   <= 1'b0;
    key_down <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : press
endmodule : frg_keypad_model

// ### tb_top.sv
// self-checking bench for the frequency reference generator
`timescale 1ns/100ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic        key_up, key_down, monitoring_mode, drive_enable, inching_command;
  logic        ramp_forward, drive_enabled, jog_active, config_incompatible_state;
  logic [7:0]  paddr;
  logic [3:0]  digital_input;
  logic [31:0] pwdata, prdata, rd_v;
  logic [15:0] ramp_reference, keypad_display;
  logic [15:0] freq_in = 16'h0060;
  logic [7:0]  src_tab [4] = '{8'h21, 8'h24, 8'h2B, 8'h2C};
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;

  frg_reference i_frg_reference (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_input(digital_input), .key_up(key_up), .key_down(key_down),
    .monitoring_mode(monitoring_mode), .drive_enable(drive_enable),
    .inching_command(inching_command), .analog_reference(16'h0050),
    .frequency_input(freq_in), .fieldbus_reference(16'h0070), .slc_reference(16'h0080),
    .ramp_reference(ramp_reference), .ramp_forward(ramp_forward),
    .drive_enabled(drive_enabled), .jog_active(jog_active),
    .config_incompatible_state(config_incompatible_state), .keypad_display(keypad_display)
  );
  frg_keypad_model i_frg_keypad_model (.pclk(pclk), .key_up(key_up), .key_down(key_down));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd_v, 32'(exp));
  endtask : rd

  // pins pass a synchroniser, so let them land before looking
  task automatic ramp_is(input logic [15:0] exp);
    repeat (10) @(posedge pclk);
    check(32'(ramp_reference), 32'(exp));
  endtask : ramp_is

  task automatic cycle_en;
    drive_enable <= 1'b0;
    repeat (10) @(posedge pclk);
    drive_enable <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask : cycle_en

  initial begin
    {presetn, psel, penable, pwrite, monitoring_mode, drive_enable, inching_command} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    digital_input = 4'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(frg_pkg::OFF_KEYPAD_REF, 16'h001E);
    rd(frg_pkg::OFF_JOG_REF, 16'h0032);
    rd(frg_pkg::OFF_LOWER_LIMIT, 16'h001E);
    rd(frg_pkg::OFF_UPPER_LIMIT, 16'h0294);
    for (int k = 0; k < 8; k++) begin
      rd(frg_pkg::OFF_PRESET_BASE + 8'(4 * k), frg_pkg::RST_PRESET[k]);
    end
    apb(1'b0, 8'h54, 32'h0000_0000);
    check(32'(err_v), 32'h0000_0001);
    apb(1'b1, frg_pkg::OFF_UPPER_LIMIT, 32'h0000_01F4);
    apb(1'b1, frg_pkg::OFF_KEYPAD_REF, 32'h0000_03E8);
    drive_enable <= 1'b1;
    apb(1'b1, frg_pkg::OFF_CONTROL_WORD, 32'h0000_0006);
    ramp_is(16'h001E);
    apb(1'b1, frg_pkg::OFF_KEYPAD_REF, 32'h0000_03E8);
    ramp_is(16'h01F4);
    // multispeed: msb on input 1, then inputs 3 and 4
    apb(1'b1, frg_pkg::OFF_DI_FUNCTION, 32'h003C_E00D);
    apb(1'b1, frg_pkg::OFF_SOURCE_SEL, 32'h0000_0028);
    for (int k = 0; k < 7; k++) apb(1'b1, frg_pkg::OFF_PRESET_BASE + 8'(4 * k), 32'(40 + 20 * k));
    apb(1'b1, frg_pkg::OFF_PRESET_BASE + 8'h1C, 32'h0000_FF9C);
    for (int k = 0; k < 7; k++) begin
      digital_input <= {k[0], k[1], 1'b0, k[2]};
      ramp_is(16'(40 + 20 * k));
    end
    digital_input <= 4'hD;
    ramp_is(16'h0064);
    check(32'(ramp_forward), 32'h0000_0000);
    apb(1'b1, frg_pkg::OFF_DI_FUNCTION, 32'h003C_E34D);
    ramp_is(16'h0064);
    check(32'(config_incompatible_state), 32'h0000_0001);
    check(32'(drive_enabled), 32'h0000_0000);
    apb(1'b1, frg_pkg::OFF_DI_FUNCTION, 32'h003C_E00D);
    inching_command <= 1'b1;
    ramp_is(16'h0032);
    check(32'(jog_active), 32'h0000_0001);
    inching_command <= 1'b0;
    // release the multispeed pins so they cannot steer the potentiometer later
    digital_input <= 4'h0;
    apb(1'b1, frg_pkg::OFF_SOURCE_SEL, 32'h0000_0020);
    monitoring_mode <= 1'b1;
    apb(1'b1, frg_pkg::OFF_KEYPAD_REF, 32'h0000_01F3);
    i_frg_keypad_model.press(1'b1);
    check(32'(keypad_display), 32'h0000_01F4);
    i_frg_keypad_model.press(1'b1);
    check(32'(keypad_display), 32'h0000_01F4);
    apb(1'b1, frg_pkg::OFF_BACKUP_MODE, 32'h0000_0001);
    cycle_en();
    check(32'(keypad_display), 32'h0000_01F4);
    apb(1'b1, frg_pkg::OFF_BACKUP_MODE, 32'h0000_0002);
    apb(1'b1, frg_pkg::OFF_SOURCE_SEL, 32'h0000_0027);
    apb(1'b1, frg_pkg::OFF_KEYPAD_REF, 32'h0000_0050);
    cycle_en();
    ramp_is(16'h0050);
    apb(1'b1, frg_pkg::OFF_EP_TICK, 32'h0000_0001);
    apb(1'b1, frg_pkg::OFF_DI_FUNCTION, 32'h0000_030B);
    apb(1'b1, frg_pkg::OFF_BACKUP_MODE, 32'h0000_0001);
    digital_input <= 4'h1;
    repeat (20) @(posedge pclk);
    digital_input <= 4'h0;
    // 20 cycles seen high after sync, one step every second cycle
    ramp_is(16'h005A);
    check(32'(ramp_reference > 16'h0050), 32'h0000_0001);
    drive_enable <= 1'b0;
    digital_input <= 4'h3;
    repeat (10) @(posedge pclk);
    digital_input <= 4'h0;
    drive_enable <= 1'b1;
    ramp_is(16'h001E);
    apb(1'b1, frg_pkg::OFF_DI_FUNCTION, 32'h0000_08A1);
    digital_input <= 4'h1;
    repeat (20) @(posedge pclk);
    digital_input <= 4'h0;
    ramp_is(16'h0028);
    check(32'(ramp_reference > 16'h001E), 32'h0000_0001);
    digital_input <= 4'h2;
    repeat (300) @(posedge pclk);
    digital_input <= 4'h0;
    ramp_is(16'h001E);
    apb(1'b1, frg_pkg::OFF_SOURCE_SEL, 32'h0000_0029);
    apb(1'b1, frg_pkg::OFF_SERIAL_REF, 32'h0000_1000);
    ramp_is(16'h012C);
    repeat (40) @(posedge pclk);
    rd(frg_pkg::OFF_SPEED_MON, 16'h1000);
    apb(1'b1, frg_pkg::OFF_SERIAL_REF, 32'h0000_7FFF);
    ramp_is(16'h01F4);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, frg_pkg::OFF_SOURCE_SEL, 32'(src_tab[k]));
      ramp_is(16'h0050 + 16'(16 * k));
    end
    // frequency input must not leak while another source is selected
    freq_in <= 16'h0100;
    ramp_is(16'h0080);
    apb(1'b1, frg_pkg::OFF_SOURCE_SEL, 32'h0000_0024);
    ramp_is(16'h0100);
    end_sim();
  end
endmodule : tb_top
